// ---- clockgen_ctrl_regs.vh ----
// Offsets, field positions, reset values and codes for control bytes 6 to 11.
`ifndef CLOCKGEN_CTRL_REGS_VH
`define CLOCKGEN_CTRL_REGS_VH
`define OFS_CLKREQ_MAP 8'h06
`define OFS_IDENT 8'h07
`define OFS_PKG_25M 8'h08
`define OFS_TEST_LVL 8'h09
`define OFS_STRAP_STOP 8'h0a
`define OFS_LP_ROUTE 8'h0b
`define RST_CLKREQ_MAP 8'h00
`define RST_PKG_25M_LOW 2'h3
`define RST_TEST_LVL 8'h25
`define RST_STRAP_STOP_LOW 2'h3
`define RST_LP_ROUTE 8'h25
`define RST_LVL 3'h5
`define RST_DRIVE 1'b1
`define MASK_CLKREQ_MAP 8'hf1
`define MASK_TEST_LVL 8'hbf
`define MASK_STRAP_STOP 8'h03
`define MASK_LP_ROUTE 8'h2d
`define MASK_PKG_25M 4'h3
`define B_CRQ_HI 7
`define B_CRQ_LO 4
`define B_CRQ_E 7
`define B_CRQ_F 6
`define B_CRQ_G 5
`define B_CRQ_H 4
`define B_PCIE_STOP 0
`define B_25M_FREE 1
`define B_25M_SHARED 0
`define B_PERIPH_STOP 7
`define B_REF_DRIVE 5
`define B_TEST_SEL 4
`define B_TEST_ENTRY 3
`define B_LVL_HI 2
`define B_LVL_LO 0
`define B_STRAP 7
`define B_PROC1_STOP 1
`define B_PROC0_STOP 0
`define B_KEEPALIVE 5
`define B_PROC2_MGMT 3
`define B_PROC1_MGMT 2
`define B_PROC2_STOP 0
`endif

// ---- clockgen_ctrl_bytes.v ----
// Control register bytes 6 to 11 of the clock generator and their output decode.
`timescale 1ns/10ps
`include "clockgen_ctrl_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview. The host reaches six control bytes through a byte-wide strobe
// interface that the management bus engine presents after decoding a frame.
// Writes land on the enabled edge that samples the strobe; reads return data
// one edge later and hold it until the next read.
// The stored fields are decoded into registered run and mode levels that the
// clock output stages use to gate their drivers. The decode is one cycle
// behind the stored bytes, so a write shows on the outputs two edges after
// the strobe. A user must allow for that lag when a stop pin and a write
// are meant to take effect together.
// Identity fields are parameters rather than storage, so no write path or
// reset can ever disturb them.

////////////////////////////////////////////////////////////////////////////////
module clockgen_ctrl_bytes #(
   parameter [3:0] REVISION_CODE = 4'h0, // Arbitrary value.
   parameter [3:0] MAKER_CODE = 4'h5, // Arbitrary value.
   parameter [3:0] PACKAGE_CODE = 4'h2 // Arbitrary value.
) (
   input wire sys_clk, // System clock, 50 MHz.
   input wire rst, // Synchronous reset, active high.
   input wire clk_en, // Clock enable; all state frozen while low, except that rst still resets it.
   input wire [7:0] reg_addr, // Byte address from the management bus engine.
   input wire [7:0] reg_wdata, // Write data byte.
   input wire reg_wr, // Write strobe, one cycle.
   input wire reg_rd, // Read strobe, one cycle.
   output reg [7:0] reg_rdata_ff, // Read data, valid the cycle after reg_rd.
   input wire strap_pin_function, // Level of the strap pin, latched after reset.
   input wire [3:0] clkreq_n, // Clock requests e..h, active low.
   input wire periph_stop_n, // Peripheral clock stop input, active low.
   input wire proc_stop_n, // Processor clock stop input, active low.
   input wire mgmt_mode_enable, // Management mode enabled.
   input wire low_power_state, // Powerdown or management low-power state.
   output reg [3:0] pcie_ref_run, // Run for pcie outputs 6, 8, 9, 10.
   output reg last_periph_run, // Run for the last free-running peripheral clock.
   output reg [2:0] proc_run, // Run for processor outputs 0..2.
   output reg freerun_25m_run, // Free-running 25 MHz output active.
   output reg shared_25m_run, // Shared 25 MHz/24.576 MHz output active.
   output reg test_mode_active, // Device is in a test mode.
   output reg test_tristate, // Test mode forcing all outputs high impedance.
   output reg test_ref_div, // Test mode driving reference divided by N.
   output reg ref_drive_strength_mid, // Reference drive-strength middle bit.
   output reg [2:0] mgmt_bus_output_level, // Bus output level code.
   output reg [1:0] mgmt_clock_route // Bit0: output 1, bit1: output 2 carry clock.
);

   reg [7:0] clkreq_map_ff;
   reg [1:0] en25m_ff;
   reg [7:0] test_lvl_ff;
   reg [1:0] proc_stop_ff;
   reg [7:0] lp_route_ff;
   reg pin_function_strap_status_ff;
   reg strap_done_ff;
   reg [7:0] nxt_rdata;
   wire clkreq_e_enable;
   wire pcie_ref_stop_control;
   wire freerun_25m_out_enable;
   wire shared_25m_audio_out_enable;
   wire last_freerun_periph_stop_control;
   wire lowpower_25m_keepalive;
   wire proc_out1_mgmt_clock_enable;
   wire proc_out2_mgmt_clock_enable;
   wire debug_port_output_enable;
   wire test_on;
   wire clkreq_f_enable;
   wire clkreq_g_enable;
   wire clkreq_h_enable;
   wire [3:0] clkreq_enables;
   wire [3:0] pcie_slot_run;
   wire periph_stop_asserted;
   wire proc_stop_asserted;
   wire pcie_group_stopped;
   wire test_select;
   reg [3:0] nxt_pcie_ref_run;
   reg nxt_last_periph_run;
   reg [2:0] nxt_proc_run;
   reg nxt_freerun_25m_run;
   reg nxt_shared_25m_run;
   reg nxt_test_mode_active;
   reg nxt_test_tristate;
   reg nxt_test_ref_div;
   reg nxt_ref_drive_strength_mid;
   reg [2:0] nxt_mgmt_bus_output_level;
   reg [1:0] nxt_mgmt_clock_route;

   // Number of pcie reference outputs that a clock request can gate.
   localparam PCIE_SLOTS = 4;
   genvar slot;

   ////////////////////////////////////////////////////////////////////////////
   // Named views of the stored fields.
   assign clkreq_e_enable = clkreq_map_ff[`B_CRQ_E];
   assign clkreq_f_enable = clkreq_map_ff[`B_CRQ_F];
   assign clkreq_g_enable = clkreq_map_ff[`B_CRQ_G];
   assign clkreq_h_enable = clkreq_map_ff[`B_CRQ_H];
   // Slot order matches the request pins: bit 3 is request e, bit 0 request h.
   assign clkreq_enables = {clkreq_e_enable, clkreq_f_enable, clkreq_g_enable,
      clkreq_h_enable};
   assign pcie_ref_stop_control = clkreq_map_ff[`B_PCIE_STOP];
   assign freerun_25m_out_enable = en25m_ff[`B_25M_FREE];
   assign shared_25m_audio_out_enable = en25m_ff[`B_25M_SHARED];
   assign last_freerun_periph_stop_control = test_lvl_ff[`B_PERIPH_STOP];
   assign lowpower_25m_keepalive = lp_route_ff[`B_KEEPALIVE];
   assign proc_out1_mgmt_clock_enable = lp_route_ff[`B_PROC1_MGMT];
   assign proc_out2_mgmt_clock_enable = lp_route_ff[`B_PROC2_MGMT];
   // The debug port enable lives outside these bytes; the strap says whether the
   // shared pin carries an output at all, so it stands in for that enable here.
   assign debug_port_output_enable = pin_function_strap_status_ff;
   assign test_on = test_lvl_ff[`B_TEST_ENTRY];
   assign test_select = test_lvl_ff[`B_TEST_SEL];
   // Stop pins are active low; these views keep the decode readable.
   assign periph_stop_asserted = ~periph_stop_n;
   assign proc_stop_asserted = ~proc_stop_n;
   assign pcie_group_stopped = pcie_ref_stop_control & periph_stop_asserted;

   ////////////////////////////////////////////////////////////////////////////
   // Per-slot request gating. A slot whose gating is off runs regardless of its
   // request pin, so an unconnected request cannot starve a board that never
   // wired it.
   generate
      for (slot = 0; slot < PCIE_SLOTS; slot = slot + 1) begin : g_pcie_slot
         assign pcie_slot_run[slot] = ~clkreq_enables[slot] | ~clkreq_n[slot];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register writes. Only writable bits are stored, so reserved and identity
   // bits cannot be disturbed by the host.
   always @(posedge sys_clk) begin
      if (rst) begin
         clkreq_map_ff <= `RST_CLKREQ_MAP;
         en25m_ff <= `RST_PKG_25M_LOW;
         test_lvl_ff <= `RST_TEST_LVL;
         proc_stop_ff <= `RST_STRAP_STOP_LOW;
         lp_route_ff <= `RST_LP_ROUTE;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `OFS_CLKREQ_MAP: clkreq_map_ff <= reg_wdata & `MASK_CLKREQ_MAP;
            `OFS_PKG_25M: en25m_ff <= reg_wdata[1:0];
            `OFS_TEST_LVL: test_lvl_ff <= reg_wdata & `MASK_TEST_LVL;
            `OFS_STRAP_STOP: proc_stop_ff <= reg_wdata[1:0];
            `OFS_LP_ROUTE: begin
               // Keep-alive is sticky at 1: once set it cannot be cleared.
               lp_route_ff <= (reg_wdata & `MASK_LP_ROUTE) |
                  {2'h0, lp_route_ff[`B_KEEPALIVE], 5'h00};
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture: taken by a clocked process on the first enabled edge after
   // reset release, since an asynchronous load of a pin value is not allowed.
   always @(posedge sys_clk) begin
      if (rst) begin
         strap_done_ff <= 1'b0;
         pin_function_strap_status_ff <= 1'b0;
      end else if (clk_en && !strap_done_ff) begin
         strap_done_ff <= 1'b1;
         pin_function_strap_status_ff <= strap_pin_function;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped addresses read zero.
   always @* begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `OFS_CLKREQ_MAP: nxt_rdata = clkreq_map_ff;
         `OFS_IDENT: nxt_rdata = {REVISION_CODE, MAKER_CODE};
         `OFS_PKG_25M: nxt_rdata = {PACKAGE_CODE, 2'h0, en25m_ff};
         `OFS_TEST_LVL: nxt_rdata = test_lvl_ff;
         `OFS_STRAP_STOP: nxt_rdata = {pin_function_strap_status_ff, 5'h00, proc_stop_ff};
         `OFS_LP_ROUTE: nxt_rdata = lp_route_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst)
         reg_rdata_ff <= 8'h00;
      else if (clk_en && reg_rd)
         reg_rdata_ff <= nxt_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output control decode, next values. Test mode overrides every run flag:
   // all run flags drop so the output stage follows the test tristate or
   // reference-divide selection instead.
   always @* begin
      // Pcie slots: request gating per slot, then the shared stop group.
      nxt_pcie_ref_run = pcie_slot_run &
         {PCIE_SLOTS{~pcie_group_stopped & ~test_on}};
      // The last free-running peripheral clock only stops when its bit allows.
      nxt_last_periph_run = ~(last_freerun_periph_stop_control & periph_stop_asserted) &
         ~test_on;
      // Processor outputs 0 and 1 take their stop enables from byte 10.
      nxt_proc_run[0] = ~(proc_stop_ff[`B_PROC0_STOP] & proc_stop_asserted) & ~test_on;
      nxt_proc_run[1] = ~(proc_stop_ff[`B_PROC1_STOP] & proc_stop_asserted) & ~test_on;
      // Processor output 2 takes its stop enable from byte 11.
      nxt_proc_run[2] = ~(lp_route_ff[`B_PROC2_STOP] & proc_stop_asserted) & ~test_on;
      // The free 25 MHz output also honours the low-power keep-alive bit.
      nxt_freerun_25m_run = freerun_25m_out_enable & ~test_on &
         (~low_power_state | lowpower_25m_keepalive);
      nxt_shared_25m_run = shared_25m_audio_out_enable & ~test_on;
      // Exactly one test kind is flagged while test mode is on.
      nxt_test_mode_active = test_on;
      nxt_test_tristate = test_on & ~test_select;
      nxt_test_ref_div = test_on & test_select;
      // Static settings pass straight through; test mode does not touch them.
      nxt_ref_drive_strength_mid = test_lvl_ff[`B_REF_DRIVE];
      nxt_mgmt_bus_output_level = test_lvl_ff[`B_LVL_HI:`B_LVL_LO];
      // Code 00 is reserved and routes nothing; output 2 needs the debug port.
      nxt_mgmt_clock_route[0] = mgmt_mode_enable & proc_out1_mgmt_clock_enable;
      nxt_mgmt_clock_route[1] = mgmt_mode_enable & proc_out2_mgmt_clock_enable &
         debug_port_output_enable;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output registers. Registered so the clock gates downstream see no glitch
   // when a stop pin and a register write change in the same cycle; the cost
   // is one cycle of extra latency on every control path.
   always @(posedge sys_clk) begin
      if (rst) begin
         // Runs stay low until the first decode after reset release.
         pcie_ref_run <= 4'h0;
         last_periph_run <= 1'b0;
         proc_run <= 3'h0;
         freerun_25m_run <= 1'b0;
         shared_25m_run <= 1'b0;
         test_mode_active <= 1'b0;
         test_tristate <= 1'b0;
         test_ref_div <= 1'b0;
         // Static settings show their power-up codes at once.
         ref_drive_strength_mid <= `RST_DRIVE;
         mgmt_bus_output_level <= `RST_LVL;
         mgmt_clock_route <= 2'h0;
      end else if (clk_en) begin
         pcie_ref_run <= nxt_pcie_ref_run;
         last_periph_run <= nxt_last_periph_run;
         proc_run <= nxt_proc_run;
         freerun_25m_run <= nxt_freerun_25m_run;
         shared_25m_run <= nxt_shared_25m_run;
         test_mode_active <= nxt_test_mode_active;
         test_tristate <= nxt_test_tristate;
         test_ref_div <= nxt_test_ref_div;
         ref_drive_strength_mid <= nxt_ref_drive_strength_mid;
         mgmt_bus_output_level <= nxt_mgmt_bus_output_level;
         mgmt_clock_route <= nxt_mgmt_clock_route;
      end
   end

endmodule // clockgen_ctrl_bytes

// ---- clockgen_ctrl_asserts.sv ----
// Checker for control bytes 6 to 11, bound to the register bank.
`timescale 1ns/10ps
module clockgen_ctrl_asserts #(
   parameter [3:0] REVISION_CODE = 4'h0, // Arbitrary value.
   parameter [3:0] MAKER_CODE = 4'h5 // Arbitrary value.
) (
   input wire sys_clk, rst, clk_en, reg_wr, reg_rd, // Clock, reset and strobes.
   input wire [7:0] reg_addr, reg_wdata, reg_rdata_ff, // Register bus.
   input wire proc_stop_n, test_mode_active, test_tristate, test_ref_div, // Stop and test.
   input wire ref_drive_strength_mid, // Drive bit.
   input wire [2:0] proc_run, mgmt_bus_output_level // Runs and level code.
);
   ////////////////////////////////////////
   // Decoded outputs lag a write by two edges: the byte is stored, then decoded.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_wr9;
      clk_en && reg_wr && reg_addr == 8'h09 ##1 clk_en;
   endsequence
   a_rst_level: assert property (disable iff (1'b0) rst && clk_en |=>
      mgmt_bus_output_level == 3'h5 && !test_mode_active) else $error("bad reset state");
   a_level_write: assert property (s_wr9 |=>
      mgmt_bus_output_level == $past(reg_wdata[2:0], 2)) else $error("bad level");
   a_drive_write: assert property (s_wr9 |=>
      ref_drive_strength_mid == $past(reg_wdata[5], 2)) else $error("bad drive bit");
   a_test_entry: assert property (s_wr9 |=>
      (test_mode_active == $past(reg_wdata[3], 2)) && (!test_mode_active || proc_run == 3'h0))
      else $error("bad test entry");
   a_test_kind: assert property ((test_tristate || test_ref_div) == test_mode_active
      && !(test_tristate && test_ref_div)) else $error("bad test kind");
   a_proc0_stop: assert property (clk_en && reg_wr && reg_addr == 8'h0a && reg_wdata[0]
      ##1 clk_en && !proc_stop_n |=> !proc_run[0]) else $error("processor output ran");
   a_ident_read: assert property (clk_en && reg_rd && reg_addr == 8'h07 |=>
      reg_rdata_ff == {REVISION_CODE, MAKER_CODE}) else $error("bad identity");
   a_unmapped_zero: assert property (clk_en && reg_rd && (reg_addr < 8'h06 ||
      reg_addr > 8'h0b) |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
   c_test_tri: cover property (test_tristate);
   c_test_div: cover property (test_ref_div);
   c_stop: cover property (!proc_stop_n && !proc_run[0]);
endmodule // clockgen_ctrl_asserts

bind clockgen_ctrl_bytes clockgen_ctrl_asserts #(.REVISION_CODE(REVISION_CODE),
   .MAKER_CODE(MAKER_CODE)) i_chk (.sys_clk, .rst, .clk_en, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata_ff, .proc_stop_n, .test_mode_active, .test_tristate,
   .test_ref_div, .ref_drive_strength_mid, .proc_run, .mgmt_bus_output_level);

// ---- clockgen_host.sv ----
// Host model issuing single-byte register reads and writes.
`timescale 1ns/10ps
module clockgen_host (
   input wire sys_clk, // Clock.
   output reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, // Address and write data.
   output reg reg_wr = 1'b0, reg_rd = 1'b0, // Strobes.
   input wire [7:0] reg_rdata_ff // Read data.
);
   ////////////////////////////////////////
   // One request held over one rising edge; stale write data is inverted afterwards.
   task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
      begin
         @(negedge sys_clk);
         {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
         @(negedge sys_clk);
         {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
         q = reg_rdata_ff;
      end
   endtask
endmodule // clockgen_host

// ---- clockgen_ctrl_bytes_tb.sv ----
// Self-checking bench for control bytes 6 to 11.
`timescale 1ns/10ps
module clockgen_ctrl_bytes_tb;
   localparam [47:0] WMASK = 48'h0d_03_bf_03_00_f1;
   localparam [47:0] RSTV = 48'h25_83_25_23_05_00;
   reg sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, strap_pin_function = 1'b1;
   reg periph_stop_n = 1'b1, proc_stop_n = 1'b1, mgmt_mode_enable = 1'b0, low_power_state = 1'b0;
   reg [3:0] clkreq_n = 4'hf;
   reg [7:0] a, d, q;
   reg [7:0] mdl [6:11];
   integer mismatches = 0, checked = 0, seed = 92855, i;
   wire [7:0] reg_addr, reg_wdata, reg_rdata_ff;
   wire [3:0] pcie_ref_run;
   wire [2:0] proc_run, mgmt_bus_output_level;
   wire [1:0] mgmt_clock_route;
   wire reg_wr, reg_rd, last_periph_run, freerun_25m_run, shared_25m_run, test_mode_active;
   wire test_tristate, test_ref_div, ref_drive_strength_mid;
   clockgen_ctrl_bytes i_dut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_ff, .strap_pin_function, .clkreq_n, .periph_stop_n, .proc_stop_n,
      .mgmt_mode_enable, .low_power_state, .pcie_ref_run, .last_periph_run, .proc_run,
      .freerun_25m_run, .shared_25m_run, .test_mode_active, .test_tristate, .test_ref_div,
      .ref_drive_strength_mid, .mgmt_bus_output_level, .mgmt_clock_route);
   clockgen_host i_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff);
   initial forever #10 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   // Comparison, access and closing tasks; the model tracks every writable bit.
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task w(input [7:0] wa, input [7:0] wd);
      begin
         i_host.acc(1'b1, wa, wd, q);
         if (wa > 8'h05 && wa < 8'h0c)
            mdl[wa] = (mdl[wa] & ~WMASK[(wa-6)*8 +: 8]) | (wd & WMASK[(wa-6)*8 +: 8]);
         repeat (2) @(negedge sys_clk);
      end
   endtask
   task r(input [7:0] ra);
      begin
         i_host.acc(1'b0, ra, 8'h00, q);
         chk(q, (ra > 8'h05 && ra < 8'h0c) ? mdl[ra] : 8'h00);
      end
   endtask
   task report_and_stop;
      begin
         $display("checked=%0d mismatches=%0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // Watchdog sized well above the roughly 1100 cycles the sequence needs.
   initial begin
      #400000;
      mismatches = mismatches + 1;
      report_and_stop;
   end
   ////////////////////////////////////////
   // Directed corners first, then random traffic over mapped and unmapped bytes.
   initial begin
      for (i = 6; i < 12; i = i + 1)
         mdl[i] = RSTV[(i-6)*8 +: 8];
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      for (i = 5; i < 13; i = i + 1)
         r(i[7:0]);
      for (i = 0; i < 4; i = i + 1) begin
         w(8'h06, 8'h10 << i);
         chk({4'h0, pcie_ref_run}, {4'h0, ~(4'h1 << i)});
         clkreq_n = ~(4'h1 << i);
         repeat (2) @(negedge sys_clk);
         chk({4'h0, pcie_ref_run}, 8'h0f);
         clkreq_n = 4'hf;
      end
      periph_stop_n = 1'b0;
      w(8'h06, 8'h01);
      chk({4'h0, pcie_ref_run}, 8'h00);
      w(8'h09, 8'ha5);
      chk({7'h0, last_periph_run}, 8'h00);
      w(8'h09, 8'h25);
      chk({7'h0, last_periph_run}, 8'h01);
      periph_stop_n = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         w(8'h08, i[7:0]);
         chk({6'h0, freerun_25m_run, shared_25m_run}, i[7:0]);
      end
      low_power_state = 1'b1;
      w(8'h0b, 8'h00);
      r(8'h0b);
      chk({7'h0, freerun_25m_run}, 8'h01);
      {low_power_state, proc_stop_n, mgmt_mode_enable} = 3'b001;
      w(8'h0a, 8'h02);
      chk({5'h0, proc_run}, 8'h05);
      w(8'h0b, 8'h2d);
      chk({5'h0, proc_run}, 8'h01);
      chk({6'h0, mgmt_clock_route}, 8'h03);
      w(8'h0a, 8'h01);
      w(8'h0b, 8'h24);
      chk({5'h0, proc_run}, 8'h06);
      chk({6'h0, mgmt_clock_route}, 8'h01);
      {proc_stop_n, mgmt_mode_enable} = 2'b10;
      for (i = 0; i < 2; i = i + 1) begin
         w(8'h09, {3'h1, i[0], 4'hd});
         chk({4'h0, test_mode_active, test_tristate, test_ref_div, |proc_run},
            {4'h0, 1'b1, ~i[0], i[0], 1'b0});
      end
      for (i = 0; i < 16; i = i + 1) begin
         w(8'h09, {2'h0, i[3], 2'h0, i[2:0]});
         chk({4'h0, ref_drive_strength_mid, mgmt_bus_output_level}, {4'h0, i[3:0]});
      end
      clk_en = 1'b0;
      i_host.acc(1'b1, 8'h06, 8'hff, q);
      clk_en = 1'b1;
      r(8'h06);
      for (i = 0; i < 300; i = i + 1) begin
         a = 8'h05 + 8'($random(seed) & 7);
         d = 8'($random(seed));
         if ($random(seed) & 1)
            w(a, d);
         else
            r(a);
      end
      report_and_stop;
   end
endmodule // clockgen_ctrl_bytes_tb
